/* core/uphy_consts.svh */
// Register offsets, field positions and reset values of the USB control bank.
// Behaviour
// [R1] Control bit 18 set turns off the data-line pulldowns; clear keeps them on.
// [R2] SE0 auto-resume sets control bit 13, held until software writes 0.
// [R3] K auto-resume sets control bit 12, held until software writes 0.
// [R4] Line-state changes pass after two to the power of bits 11:8 cycles.
// [R5] Bit 7 set lets the hardware suspend controller handle resume.
// [R6] Control bits 6:4 drive the three transceiver config pins; reset zero.
// [R7] Reserved bits of power and control registers read zero, ignore writes.
`ifndef UPHY_CONSTS_SVH
`define UPHY_CONSTS_SVH
`define UPHY_OFS_OTG_MASK 12'h038
`define UPHY_OFS_PWRSIG 12'h03c
`define UPHY_OFS_CTRL 12'h040
`define UPHY_PWRSIG_MASK 32'h0000_01ff
`define UPHY_CTRL_MASK 32'h0004_3ff0
`define UPHY_BIT_PULLDOWN_OFF 18
`define UPHY_BIT_RESUME_SE0 13
`define UPHY_BIT_RESUME_K 12
`define UPHY_FILT_LSB 8
`define UPHY_BIT_HW_RESUME 7
`define UPHY_CONF_LSB 4
`define UPHY_RESET_VALUE 32'h0000_0000
`endif

/* core/uphy_pkg.sv */
// Types shared by the USB control bank.
package uphy_pkg;
   typedef struct packed {
      logic [11:0] paddr;
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] pwdata;
   } uphy_apb_req_t;
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } uphy_apb_rsp_t;
   typedef enum logic [1:0] {
      UPHY_LS_SE0 = 2'b00,
      UPHY_LS_J = 2'b01,
      UPHY_LS_K = 2'b10,
      UPHY_LS_SE1 = 2'b11
   } uphy_linestate_t;
endpackage : uphy_pkg

/* core/uphy_regs.sv */
// APB register bank for the USB transceiver control and line filter.
`timescale 1ns/1ps
`include "uphy_consts.svh"
module uphy_regs
   import uphy_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire uphy_apb_req_t apb_req,
   output uphy_apb_rsp_t apb_rsp,
   input wire logic [1:0] line_state_raw,
   input wire logic resume_se0_event,
   input wire logic resume_k_event,
   output logic [1:0] line_state_filt,
   output logic pulldown_disable,
   output logic hw_resume_enable,
   output logic [2:0] transceiver_config_pins,
   output logic [31:0] otg_mask_bits,
   output logic power_signal_valid,
   output logic [7:0] power_signal_value
);
   logic [31:0] otg_event_mask;
   logic [31:0] usb_power_signalling;
   logic [31:0] usb_transceiver_control;
   logic [15:0] filt_count;
   logic [1:0] filt_candidate;
   logic [15:0] filt_limit;
   logic wr_en;
   logic rd_en;
   logic [31:0] next_rdata;
   logic hit;

   assign wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite;
   assign rd_en = apb_req.psel && !apb_req.penable && !apb_req.pwrite;

   always_comb begin
      hit = 1'b1;
      next_rdata = 32'h0000_0000;
      unique case (apb_req.paddr)
         `UPHY_OFS_OTG_MASK: next_rdata = otg_event_mask;
         `UPHY_OFS_PWRSIG: next_rdata = usb_power_signalling;
         `UPHY_OFS_CTRL: next_rdata = usb_transceiver_control;
         default: hit = 1'b0;
      endcase
   end

   // Zero wait states: pready rises in every access phase.
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         apb_rsp <= '0;
      end else begin
         apb_rsp.pready <= apb_req.psel && !apb_req.penable;
         apb_rsp.pslverr <= apb_req.psel && !apb_req.penable && !hit;
         if (rd_en) begin
            apb_rsp.prdata <= next_rdata;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         otg_event_mask <= `UPHY_RESET_VALUE;
         usb_power_signalling <= `UPHY_RESET_VALUE;
      end else if (wr_en && apb_req.paddr == `UPHY_OFS_OTG_MASK) begin
         otg_event_mask <= apb_req.pwdata;
      end else if (wr_en && apb_req.paddr == `UPHY_OFS_PWRSIG) begin
         usb_power_signalling <= apb_req.pwdata & `UPHY_PWRSIG_MASK; // R7
      end
   end

   // A resume event in the cycle of a clearing write keeps its flag set.
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         usb_transceiver_control <= `UPHY_RESET_VALUE;
      end else begin
         if (wr_en && apb_req.paddr == `UPHY_OFS_CTRL) begin
            usb_transceiver_control <= apb_req.pwdata & `UPHY_CTRL_MASK; // R7
         end
         if (resume_se0_event) begin
            usb_transceiver_control[`UPHY_BIT_RESUME_SE0] <= 1'b1; // R2
         end
         if (resume_k_event) begin
            usb_transceiver_control[`UPHY_BIT_RESUME_K] <= 1'b1; // R3
         end
      end
   end

   assign filt_limit = 16'h0001 <<
      usb_transceiver_control[`UPHY_FILT_LSB +: 4];

   // A new line state must stand for 2**n cycles before it is passed on.
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         filt_candidate <= UPHY_LS_SE0;
         filt_count <= 16'h0000;
         line_state_filt <= UPHY_LS_SE0;
      end else if (line_state_raw != filt_candidate) begin
         filt_candidate <= line_state_raw; // R4
         filt_count <= 16'h0001;
      end else if (filt_candidate != line_state_filt) begin
         if (filt_count >= filt_limit) begin
            line_state_filt <= filt_candidate; // R4
         end else begin
            filt_count <= filt_count + 16'h0001;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         pulldown_disable <= 1'b0;
         hw_resume_enable <= 1'b0;
         transceiver_config_pins <= 3'h0;
         otg_mask_bits <= 32'h0000_0000;
         power_signal_valid <= 1'b0;
         power_signal_value <= 8'h00;
      end else begin
         pulldown_disable <=
            usb_transceiver_control[`UPHY_BIT_PULLDOWN_OFF]; // R1
         hw_resume_enable <=
            usb_transceiver_control[`UPHY_BIT_HW_RESUME]; // R5
         transceiver_config_pins <=
            usb_transceiver_control[`UPHY_CONF_LSB +: 3]; // R6
         otg_mask_bits <= otg_event_mask;
         power_signal_valid <= usb_power_signalling[8];
         power_signal_value <= usb_power_signalling[7:0];
      end
   end
endmodule : uphy_regs

/* dv/uphy_regs_monitor.sv */
// Port checker for the USB control register bank.
`timescale 1ns/1ps
module uphy_regs_monitor
   import uphy_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire uphy_apb_req_t apb_req,
   input wire uphy_apb_rsp_t apb_rsp,
   input wire logic pulldown_disable,
   input wire logic hw_resume_enable,
   input wire logic [2:0] transceiver_config_pins,
   input wire logic [1:0] line_state_raw,
   input wire logic [1:0] line_state_filt
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   wire [11:0] a = apb_req.paddr;
   wire [31:0] d = apb_req.pwdata;
   wire ok = apb_req.psel && apb_req.penable && apb_rsp.pready;
   wire wc = ok && apb_req.pwrite && a == 12'h040;
   // Bits that must read zero at each address; all of them where unmapped.
   wire [31:0] rsv = a == 12'h040 ? 32'hfffb_c00f : a == 12'h03c ?
      32'hffff_fe00 : a == 12'h038 ? 32'h0 : '1;
   wire [4:0] o = {pulldown_disable, hw_resume_enable,
      transceiver_config_pins};
   a_out_follow: assert property (wc |-> ##2
      o == $past({d[18], d[7], d[6:4]}, 2)) else $error("outputs wrong");
   a_out_cause: assert property ($changed(o) |-> $past(wc, 2))
      else $error("outputs moved");
   a_rsvd_zero: assert property (ok && !apb_req.pwrite
      |-> (apb_rsp.prdata & rsv) == 0) else $error("reserved bits set");
   a_err_flag: assert property (ok && rsv == '1 |-> apb_rsp.pslverr)
      else $error("no error on unmapped");
   a_ready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready)
      else $error("ready held");
   a_filt_stable: assert property ($changed(line_state_filt) |->
      line_state_filt == $past(line_state_raw))
      else $error("filtered state not from a stable raw state");
endmodule : uphy_regs_monitor
bind uphy_regs uphy_regs_monitor mon_u (.*);

/* dv/uphy_phy_model.sv */
// Transceiver stand-in driving line state and one-cycle resume pulses.
`timescale 1ns/1ps
module uphy_phy_model (
   input wire logic clk_sys,
   input wire logic [3:0] cmd,
   output logic [1:0] line_state_raw = 2'h1,
   output logic resume_se0_event = 1'b0,
   output logic resume_k_event = 1'b0
);
   always @(posedge clk_sys) begin
      line_state_raw <= cmd[1:0];
      {resume_k_event, resume_se0_event} <= cmd[3:2];
   end
endmodule : uphy_phy_model

/* dv/test_uphy_regs.sv */
// Self-checking bench for the USB control register bank.
`timescale 1ns/1ps
module test_uphy_regs import uphy_pkg::*; ;
   logic clk_sys = 0, reset = 1, er, pulldown_disable, hw_resume_enable;
   logic power_signal_valid, resume_se0_event, resume_k_event;
   logic [1:0] line_state_raw, line_state_filt;
   logic [2:0] transceiver_config_pins;
   logic [3:0] cmd = 4'h1;
   logic [7:0] power_signal_value;
   logic [31:0] otg_mask_bits, rd;
   uphy_apb_req_t apb_req = '0;
   uphy_apb_rsp_t apb_rsp;
   int fail_count = 0, checked = 0;
   wire [4:0] o = {pulldown_disable, hw_resume_enable,
      transceiver_config_pins};
   typedef struct {logic [11:0] a; logic [31:0] d, r; logic [4:0] o;}
      uphy_row_t;
   uphy_row_t rows [6] = '{'{12'h038, '1, '1, '0},
      '{12'h03c, '1, 32'h1ff, '0}, '{12'h040, '1, 32'h43ff0, 5'h1f},
      '{12'h040, 32'h50, 32'h50, 5'h5}, '{12'h040, 32'h40080, 32'h40080,
      5'h18}, '{12'h050, '1, '0, 5'h18}};
   uphy_phy_model phy_u (.*);
   uphy_regs dut_u (.*);
   initial forever #20 clk_sys = ~clk_sys;
   initial #200us test_done(1);
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         fail_count++;
         $display("ERROR %0t seen %h expected %h", $time, s, e);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      apb_req <= '{a, 1'b1, 1'b0, w, d};
      @(posedge clk_sys) apb_req.penable <= 1'b1;
      do @(posedge clk_sys); while (apb_rsp.pready !== 1'b1);
      {rd, er} = {apb_rsp.prdata, apb_rsp.pslverr};
      apb_req <= '0;
      @(posedge clk_sys);
   endtask : apb
   task automatic test_done(input int extra);
      fail_count += extra;
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : test_done
   initial begin
      repeat (3) @(posedge clk_sys);
      reset <= 0;
      foreach (rows[i]) begin
         apb(1, rows[i].a, rows[i].d);
         apb(0, rows[i].a, '0);
         chk(rd, rows[i].r);
         chk(o, rows[i].o);
      end
      chk(er, 1'b1);
      chk(otg_mask_bits, '1);
      chk({power_signal_valid, power_signal_value}, 32'h1ff);
      $display("register rows done");
      for (int k = 0; k < 2; k++) begin
         cmd <= 4'h1 | 4'h4 << k;
         @(posedge clk_sys) cmd <= 4'h1;
         repeat (2) @(posedge clk_sys);
         apb(0, 12'h040, '0);
         chk(rd, 32'h40080 | 32'h2000 >> k);
         apb(1, 12'h040, 32'h40080);
         apb(0, 12'h040, '0);
         chk(rd, 32'h40080);
      end
      apb(1, 12'h040, 32'h200);
      cmd <= 4'h2;
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys) chk(line_state_filt, 2'h1);
      repeat (8) @(posedge clk_sys);
      @(negedge clk_sys) chk(line_state_filt, 2'h2);
      $display("resume and filter done");
      @(posedge clk_sys) reset <= 1;
      @(negedge clk_sys) chk(o, '0);
      @(posedge clk_sys) reset <= 0;
      apb(0, 12'h040, '0);
      chk(rd, '0);
      $display("reset done");
      test_done(0);
   end
endmodule : test_uphy_regs
